// *** design/ots_master.sv ***
// controller end: byte-level two-wire master with divided clock
`timescale 1ns/1ps
module ots_master (
  input wire logic clock,
  input wire logic resetn,
  ots_if.master bus,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic cmdStart,
  input wire logic cmdStop,
  input wire logic cmdRead,
  input wire logic cmdAck,
  input wire logic [ots_pkg::BYTE_BITS-1:0] cmdData,
  output logic rspValid,
  output logic [ots_pkg::BYTE_BITS-1:0] rspData,
  output logic rspAckd
);
  import ots_pkg::*;

  typedef enum logic [2:0] {M_IDLE, M_HOLD, M_START, M_BITS, M_STOP} ots_master_state_t;

  logic sdaS1_reg;
  logic sdaS2_reg;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sdaS1_reg <= 1'h1;
      sdaS2_reg <= 1'h1;
    end else begin
      sdaS1_reg <= bus.sdaLine;
      sdaS2_reg <= sdaS1_reg;
    end
  end

  ots_master_state_t state_reg;
  ots_master_state_t state_next;
  logic [7:0] qCyc_reg;
  logic [7:0] qCyc_next;
  logic [1:0] q_reg;
  logic [1:0] q_next;
  logic [3:0] bit_reg;
  logic [3:0] bit_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic read_reg;
  logic read_next;
  logic ackWant_reg;
  logic ackWant_next;
  logic stop_reg;
  logic stop_next;
  logic sclDriveN_reg;
  logic sclDriveN_next;
  logic sdaDriveN_reg;
  logic sdaDriveN_next;
  logic rspValid_reg;
  logic rspValid_next;
  logic [7:0] rspData_reg;
  logic [7:0] rspData_next;
  logic rspAckd_reg;
  logic rspAckd_next;
  logic tick;
  logic sclLow;
  logic sdaLow;
  logic sdaHold;

  assign tick = (qCyc_reg == QTR_LAST);
  assign cmdReady = (state_reg == M_IDLE) || (state_reg == M_HOLD);

  always_comb begin
    state_next = state_reg;
    qCyc_next = tick ? 8'h00 : qCyc_reg + 8'h01;
    q_next = q_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    read_next = read_reg;
    ackWant_next = ackWant_reg;
    stop_next = stop_reg;
    rspValid_next = 1'h0;
    rspData_next = rspData_reg;
    rspAckd_next = rspAckd_reg;
    sclLow = 1'h0;
    sdaLow = 1'h0;
    // data-bit sda moves only in the second low quarter; START and STOP move it in the last high quarter
    sdaHold = (q_reg == 2'h0) || (state_reg == M_HOLD);
    unique case (state_reg)
      M_IDLE: begin
        sdaHold = 1'h0;
      end
      M_HOLD: begin
        sclLow = 1'h1;
      end
      M_START: begin
        sclLow = q_reg < QTR_FIRST_HIGH;
        sdaLow = q_reg == QTR_LAST_IDX; // see [R4] [R15]
      end
      M_BITS: begin
        sclLow = q_reg < QTR_FIRST_HIGH;
        if (bit_reg == ACK_BIT) begin
          sdaLow = read_reg && ackWant_reg; // see [R14]
        end else begin
          sdaLow = !read_reg && !shift_reg[7];
        end
      end
      M_STOP: begin
        sclLow = q_reg < QTR_FIRST_HIGH;
        sdaLow = (q_reg == 2'h1) || (q_reg == QTR_FIRST_HIGH); // see [R4]
      end
    endcase
    if (cmdReady) begin
      qCyc_next = 8'h00;
      q_next = 2'h0;
      if (cmdValid) begin
        state_next = cmdStart ? M_START : M_BITS; // see [R6] [R12]
        bit_next = 4'h0;
        shift_next = cmdData;
        read_next = cmdRead;
        ackWant_next = cmdAck;
        stop_next = cmdStop;
      end
    end else if (tick) begin
      q_next = q_reg + 2'h1;
      if (q_reg == QTR_LAST_IDX) begin
        unique case (state_reg)
          M_START: begin
            state_next = M_BITS;
          end
          M_STOP: begin
            state_next = M_IDLE;
          end
          default: begin
            bit_next = bit_reg + 4'h1;
            if (bit_reg == ACK_BIT) begin
              rspAckd_next = ~sdaS2_reg;
              rspData_next = shift_reg;
              rspValid_next = 1'h1;
              state_next = stop_reg ? M_STOP : M_HOLD;
            end else begin
              shift_next = {shift_reg[6:0], sdaS2_reg};
            end
          end
        endcase
      end
    end
    sclDriveN_next = !sclLow;
    sdaDriveN_next = sdaHold ? sdaDriveN_reg : !sdaLow;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= M_IDLE;
      qCyc_reg <= 8'h00;
      q_reg <= 2'h0;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      read_reg <= 1'h0;
      ackWant_reg <= 1'h0;
      stop_reg <= 1'h0;
      sclDriveN_reg <= 1'h1;
      sdaDriveN_reg <= 1'h1;
      rspValid_reg <= 1'h0;
      rspData_reg <= 8'h00;
      rspAckd_reg <= 1'h0;
    end else begin
      state_reg <= state_next;
      qCyc_reg <= qCyc_next;
      q_reg <= q_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      read_reg <= read_next;
      ackWant_reg <= ackWant_next;
      stop_reg <= stop_next;
      sclDriveN_reg <= sclDriveN_next;
      sdaDriveN_reg <= sdaDriveN_next;
      rspValid_reg <= rspValid_next;
      rspData_reg <= rspData_next;
      rspAckd_reg <= rspAckd_next;
    end
  end

  assign bus.mSclOut = 1'h0;
  assign bus.mSclDriveN = sclDriveN_reg;
  assign bus.mSdaOut = 1'h0;
  assign bus.mSdaDriveN = sdaDriveN_reg;
  assign rspValid = rspValid_reg;
  assign rspData = rspData_reg;
  assign rspAckd = rspAckd_reg;
endmodule // ots_master

// *** design/ots_slave.sv ***
// transceiver end: two-wire slave with auto-incrementing register index
`timescale 1ns/1ps
module ots_slave (
  input wire logic clock,
  input wire logic resetn,
  ots_if.slave bus,
  input wire logic addressSelectStrapPin,
  output logic [ots_pkg::BYTE_BITS-1:0] regAddr,
  output logic regWrEn,
  output logic [ots_pkg::BYTE_BITS-1:0] regWrData,
  input wire logic [ots_pkg::BYTE_BITS-1:0] regRdData,
  input wire logic regExists,
  output logic addressStrapBit
);
  import ots_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_INDEX, S_WDATA, S_ACK, S_RDATA, S_RACK, S_IGNORE
  } ots_slave_state_t;

  logic sclS1_reg;
  logic sclS2_reg;
  logic sclS3_reg;
  logic sdaS1_reg;
  logic sdaS2_reg;
  logic sdaS3_reg;
  logic strapS1_reg;
  logic strapS2_reg;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;

  // synchronisers; third stage is history for edge finding
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sclS1_reg <= 1'h1;
      sclS2_reg <= 1'h1;
      sclS3_reg <= 1'h1;
      sdaS1_reg <= 1'h1;
      sdaS2_reg <= 1'h1;
      sdaS3_reg <= 1'h1;
    end else begin
      sclS1_reg <= bus.sclLine;
      sclS2_reg <= sclS1_reg;
      sclS3_reg <= sclS2_reg;
      sdaS1_reg <= bus.sdaLine;
      sdaS2_reg <= sdaS1_reg;
      sdaS3_reg <= sdaS2_reg;
    end
  end

  // no reset: the strap is tracked while reset is held, so its level under reset is caught
  always_ff @(posedge clock) begin
    strapS1_reg <= addressSelectStrapPin;
    strapS2_reg <= strapS1_reg;
  end

  assign sclRise = sclS2_reg & ~sclS3_reg;
  assign sclFall = ~sclS2_reg & sclS3_reg;
  assign startSeen = sclS2_reg & sclS3_reg & sdaS3_reg & ~sdaS2_reg;
  assign stopSeen = sclS2_reg & sclS3_reg & ~sdaS3_reg & sdaS2_reg;

  // strap capture; flops cannot load a pin under async reset, so sample after release
  logic [1:0] strapCnt_reg;
  logic [1:0] strapCnt_next;
  logic strapBit_reg;
  logic strapBit_next;

  always_comb begin
    strapCnt_next = strapCnt_reg;
    strapBit_next = strapBit_reg;
    if (strapCnt_reg != STRAP_SETTLE) begin
      strapCnt_next = strapCnt_reg + 2'h1;
      strapBit_next = strapS2_reg; // see [R2]
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      strapCnt_reg <= 2'h0;
      strapBit_reg <= 1'h0;
    end else begin
      strapCnt_reg <= strapCnt_next;
      strapBit_reg <= strapBit_next;
    end
  end

  ots_slave_state_t state_reg;
  ots_slave_state_t state_next;
  ots_slave_state_t after_reg;
  ots_slave_state_t after_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [3:0] bitCnt_reg;
  logic [3:0] bitCnt_next;
  logic [7:0] index_reg;
  logic [7:0] index_next;
  logic [7:0] addr_reg;
  logic [7:0] addr_next;
  logic sdaDriveN_reg;
  logic sdaDriveN_next;
  logic wrEn_reg;
  logic wrEn_next;
  logic [7:0] wrData_reg;
  logic [7:0] wrData_next;
  logic masterAck_reg;
  logic masterAck_next;
  logic readOk_reg;
  logic readOk_next;

  always_comb begin
    state_next = state_reg;
    after_next = after_reg;
    shift_next = shift_reg;
    bitCnt_next = bitCnt_reg;
    index_next = index_reg;
    addr_next = addr_reg;
    sdaDriveN_next = sdaDriveN_reg;
    wrEn_next = 1'h0;
    wrData_next = wrData_reg;
    masterAck_next = masterAck_reg;
    readOk_next = readOk_reg;
    if (stopSeen) begin
      state_next = S_IDLE; // see [R15]
      sdaDriveN_next = 1'h1;
      addr_next = index_reg; // see [R13]
    end else if (startSeen) begin
      state_next = S_ADDR; // see [R15]
      bitCnt_next = 4'h0;
      sdaDriveN_next = 1'h1;
      addr_next = index_reg;
    end else begin
      unique case (state_reg)
        S_IDLE, S_IGNORE: begin
          sdaDriveN_next = 1'h1; // see [R16]
        end
        S_ADDR, S_INDEX, S_WDATA: begin
          if (sclRise) begin
            shift_next = {shift_reg[6:0], sdaS2_reg}; // see [R4]
            bitCnt_next = bitCnt_reg + 4'h1;
            // present the candidate index early so the map can answer before the ack
            if (state_reg == S_INDEX && bitCnt_reg == LAST_DATA_BIT) begin
              addr_next = {shift_reg[6:0], sdaS2_reg};
            end
          end else if (sclFall && bitCnt_reg == ACK_BIT) begin
            bitCnt_next = 4'h0;
            state_next = S_IGNORE;
            if (state_reg == S_ADDR) begin
              if (shift_reg[7:1] == {DEV_ADDR_HI, strapBit_reg}) begin // see [R1]
                sdaDriveN_next = 1'h0; // see [R5]
                state_next = S_ACK;
                after_next = (shift_reg[0] == RW_READ) ? S_RDATA : S_INDEX; // see [R3]
              end
            end else if (state_reg == S_INDEX) begin
              if (regExists) begin
                index_next = addr_reg; // see [R12]
                sdaDriveN_next = 1'h0; // see [R5]
                state_next = S_ACK;
                after_next = S_WDATA; // see [R6]
              end else begin
                addr_next = index_reg; // see [R9]
              end
            end else begin
              if (regExists) begin
                wrEn_next = 1'h1; // see [R7]
                wrData_next = shift_reg;
                index_next = index_reg + INDEX_STEP; // see [R8] [R10]
                // map address held at the written register until the strobe has passed
                sdaDriveN_next = 1'h0; // see [R5]
                state_next = S_ACK;
                after_next = S_WDATA;
              end
            end
          end
        end
        S_ACK: begin
          if (sclFall) begin
            sdaDriveN_next = 1'h1;
            addr_next = index_reg; // see [R8]
            state_next = after_reg;
            if (after_reg == S_RDATA) begin
              shift_next = regExists ? regRdData : READ_FILL; // see [R11]
              readOk_next = regExists;
              sdaDriveN_next = regExists ? regRdData[7] : READ_FILL[7];
            end
          end
        end
        S_RDATA: begin
          if (sclFall) begin
            bitCnt_next = bitCnt_reg + 4'h1;
            shift_next = {shift_reg[6:0], 1'h1};
            sdaDriveN_next = shift_reg[6];
            if (bitCnt_reg == LAST_DATA_BIT) begin
              bitCnt_next = 4'h0;
              sdaDriveN_next = 1'h1;
              state_next = S_RACK;
            end
          end
        end
        S_RACK: begin
          if (sclRise) begin
            masterAck_next = ~sdaS2_reg;
            if (readOk_reg) begin
              index_next = index_reg + INDEX_STEP; // see [R14] [R10]
              addr_next = index_reg + INDEX_STEP;
            end
          end else if (sclFall) begin
            state_next = S_IGNORE; // see [R14]
            if (masterAck_reg) begin
              state_next = S_RDATA;
              shift_next = regExists ? regRdData : READ_FILL;
              readOk_next = regExists;
              sdaDriveN_next = regExists ? regRdData[7] : READ_FILL[7];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= S_IDLE;
      after_reg <= S_IDLE;
      shift_reg <= 8'h00;
      bitCnt_reg <= 4'h0;
      index_reg <= INDEX_RESET;
      addr_reg <= INDEX_RESET;
      sdaDriveN_reg <= 1'h1;
      wrEn_reg <= 1'h0;
      wrData_reg <= 8'h00;
      masterAck_reg <= 1'h0;
      readOk_reg <= 1'h0;
    end else begin
      state_reg <= state_next;
      after_reg <= after_next;
      shift_reg <= shift_next;
      bitCnt_reg <= bitCnt_next;
      index_reg <= index_next;
      addr_reg <= addr_next;
      sdaDriveN_reg <= sdaDriveN_next;
      wrEn_reg <= wrEn_next;
      wrData_reg <= wrData_next;
      masterAck_reg <= masterAck_next;
      readOk_reg <= readOk_next;
    end
  end

  // open drain: only ever pull low
  assign bus.sSdaOut = 1'h0;
  assign bus.sSdaDriveN = sdaDriveN_reg;
  assign regAddr = addr_reg;
  assign regWrEn = wrEn_reg;
  assign regWrData = wrData_reg;
  assign addressStrapBit = strapBit_reg;
endmodule // ots_slave

// *** pkg/ots_if.sv ***
// open-drain two-wire link joining controller end and transceiver end
`timescale 1ns/1ps
interface ots_if;
  logic sclLine;
  logic sdaLine;
  logic mSclOut;
  logic mSclDriveN;
  logic mSdaOut;
  logic mSdaDriveN;
  logic sSdaOut;
  logic sSdaDriveN;
  // wired-and with pull-ups: a line is low only while some end pulls it
  assign sclLine = !(!mSclDriveN && !mSclOut);
  assign sdaLine = !((!mSdaDriveN && !mSdaOut) || (!sSdaDriveN && !sSdaOut));
  modport master (input sdaLine, output mSclOut, output mSclDriveN, output mSdaOut,
    output mSdaDriveN);
  modport slave (input sclLine, input sdaLine, output sSdaOut, output sSdaDriveN);
endinterface

// *** pkg/ots_pkg.sv ***
// shared constants for the transceiver control-port link
// How it works
// [R1] respond only to address 010110 plus strap bit
// [R2] strap bit caught at reset, held till next
// [R3] first byte bit 0: 0 write, 1 read
// [R4] start, acked 8-bit bytes, stop by master
// [R5] slave acks address, index, accepted write data
// [R6] master write: address, index, data, stop
// [R7] first data byte lands at indexed register
// [R8] index advances by one after each write
// [R9] missing register: nack, index kept
// [R10] index wraps from 255 to 0
// [R11] current-address read uses present index
// [R12] random read: set index, then read from it
// [R13] index survives between transactions
// [R14] index advances per read byte; master nack ends
// [R15] repeated start restarts decode; stop releases sda
// [R16] foreign address ignored, sda released, index kept
package ots_pkg;
  localparam int BYTE_BITS = 8;
  localparam logic [5:0] DEV_ADDR_HI = 6'h16;
  localparam logic RW_WRITE = 1'h0;
  localparam logic RW_READ = 1'h1;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [7:0] INDEX_RESET = 8'h00;
  localparam logic [7:0] INDEX_STEP = 8'h01;
  localparam logic [7:0] READ_FILL = 8'hff;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCL_PERIOD_NS = 80;
  localparam int SCL_QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [7:0] QTR_LAST = 8'(SCL_QUARTER_CYC - 1);
  localparam logic [1:0] QTR_FIRST_HIGH = 2'h2;
  localparam logic [1:0] QTR_LAST_IDX = 2'h3;
endpackage

// *** verif/ots_sva.sv ***
// checker for the shared two-wire lines: framing, ack slots, release
`timescale 1ns/1ps
module ots_sva (
  input wire logic clock,
  input wire logic resetn,
  input wire logic sclLine,
  input wire logic sdaLine,
  input wire logic mSdaDriveN,
  input wire logic sSdaDriveN,
  input wire logic addressStrapBit
);
  import ots_pkg::*;
  logic sclQ;
  logic sdaQ;
  logic rdEnd;
  logic inData;
  logic [3:0] bitCnt;
  logic [7:0] first;
  logic [2:0] upCnt;
  wire sclRise = sclLine && !sclQ;
  wire stopSeen = sclLine && sclQ && !sdaQ && sdaLine;
  wire ackRise = sclRise && bitCnt == ACK_BIT;
  wire addrAck = ackRise && !inData;
  wire rdNow = inData && first[0] == RW_READ;
  wire mine = first[7:1] == {DEV_ADDR_HI, addressStrapBit};
  // first byte is frozen once past its ack, so a foreign frame stays flagged till START
  wire alien = inData && !mine;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sclQ <= 1'h1;
      sdaQ <= 1'h1;
      rdEnd <= 1'h0;
      inData <= 1'h0;
      bitCnt <= 4'h0;
      first <= 8'h00;
      upCnt <= 3'h0;
    end else begin
      sclQ <= sclLine;
      sdaQ <= sdaLine;
      upCnt <= upCnt + 3'(upCnt != 3'h7);
      if (sclLine && sclQ && sdaQ && !sdaLine) begin
        bitCnt <= 4'h0;
        inData <= 1'h0;
        rdEnd <= 1'h0;
      end else if (ackRise) begin
        bitCnt <= 4'h0;
        inData <= 1'h1;
        // master nack ends the read; the STOP rise after it is not a data bit
        rdEnd <= rdEnd || (rdNow && sdaLine);
      end else if (sclRise) begin
        bitCnt <= bitCnt + 4'h1;
        first <= inData ? first : {first[6:0], sdaLine};
      end
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  a_addr_ack_low: assert property (addrAck && mine |-> !sdaLine)
    else $error("own address not acked");
  a_alien_no_ack: assert property (addrAck && !mine |-> sSdaDriveN)
    else $error("foreign address acked");
  a_alien_stays_quiet: assert property (alien |-> sSdaDriveN)
    else $error("sda driven in foreign frame");
  a_write_bits_free: assert property (sclRise && bitCnt != ACK_BIT && !rdNow |-> sSdaDriveN)
    else $error("slave drove master bit");
  a_read_bits_own: assert property (sclRise && bitCnt != ACK_BIT && rdNow && !rdEnd |-> mSdaDriveN)
    else $error("master drove read bit");
  a_read_ack_free: assert property (ackRise && rdNow |-> sSdaDriveN)
    else $error("slave drove master ack");
  a_high_sda_still: assert property (sclLine && sclQ |-> $stable(sSdaDriveN))
    else $error("slave moved sda while scl high");
  a_stop_released: assert property (stopSeen |=> sSdaDriveN [*8])
    else $error("sda held after stop");
  a_scl_high_eight: assert property ($rose(sclLine) |-> sclLine [*8])
    else $error("scl high too short");
  a_strap_held: assert property (upCnt == 3'h7 |-> $stable(addressStrapBit))
    else $error("strap bit moved");
endmodule // ots_sva

// *** verif/tb.sv ***
// bench: both link ends joined, a small register map, directed and random traffic
`timescale 1ns/1ps
module tb;
  import ots_pkg::*;
  logic clock;
  logic resetn;
  logic strapPin;
  logic strapBit;
  logic cmdValid;
  logic cmdReady;
  logic [11:0] cmdWord;
  logic rspValid;
  logic [7:0] rspData;
  logic rspAckd;
  logic [7:0] regAddr;
  logic regWrEn;
  logic [7:0] regWrData;
  logic [6:0] myAddr;
  logic [7:0] expIndex;
  logic [7:0] mem [256];
  logic [7:0] expMem [256];
  int errorCnt = 0;
  int comparisons = 0;
  int seed = 7598;
  // holes at e0..ef; the top register stays real so the wrap is exercised
  function automatic logic present(input logic [7:0] k);
    return k[7:4] != 4'he;
  endfunction
  ots_if link ();
  ots_master u_ots_master (.clock(clock), .resetn(resetn), .bus(link), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdStart(cmdWord[11]), .cmdStop(cmdWord[10]), .cmdRead(cmdWord[9]),
    .cmdAck(cmdWord[8]), .cmdData(cmdWord[7:0]), .rspValid(rspValid), .rspData(rspData),
    .rspAckd(rspAckd));
  ots_slave u_ots_slave (.clock(clock), .resetn(resetn), .bus(link),
    .addressSelectStrapPin(strapPin), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdData(mem[regAddr]), .regExists(present(regAddr)),
    .addressStrapBit(strapBit));
  ots_sva u_ots_sva (.clock(clock), .resetn(resetn), .sclLine(link.sclLine),
    .sdaLine(link.sdaLine), .mSdaDriveN(link.mSdaDriveN), .sSdaDriveN(link.sSdaDriveN),
    .addressStrapBit(strapBit));
  always @(posedge clock) begin
    if (regWrEn === 1'h1) begin
      mem[regAddr] <= regWrData;
    end
  end
  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    comparisons++;
    if (seen !== exp) begin
      errorCnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finishTest();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // sampled at the falling edge, where the design's registers have settled
  task automatic waitHigh(input logic rsp);
    int n;
    n = 0;
    @(negedge clock);
    while ((rsp ? rspValid : cmdReady) !== 1'h1) begin
      n++;
      if (n > 400) begin
        check("handshake", 8'h01, 8'h00);
        finishTest();
      end
      @(negedge clock);
    end
  endtask
  task automatic xfer(input logic [3:0] f, input logic [7:0] d);
    @(posedge clock);
    cmdValid <= 1'h1;
    cmdWord <= {f, d};
    waitHigh(1'h0);
    @(posedge clock);
    cmdValid <= 1'h0;
    waitHigh(1'h1);
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] idx, input int n);
    logic live;
    logic [7:0] d;
    live = dev == myAddr;
    xfer(4'h8, {dev, RW_WRITE});
    check("address ack", 8'(live), 8'(rspAckd));
    xfer(4'h0, idx);
    live = live && present(idx);
    check("index ack", 8'(live), 8'(rspAckd));
    expIndex = live ? idx : expIndex;
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      xfer({1'h0, 1'(i == n - 1), 2'h0}, d);
      live = live && present(expIndex);
      check("data ack", 8'(live), 8'(rspAckd));
      if (live) begin
        expMem[expIndex] = d;
        expIndex = expIndex + INDEX_STEP;
      end
    end
    $display("write test done at %h, %0d bytes", idx, n);
  endtask
  task automatic rd(input logic [6:0] dev, input logic setIdx, input logic [7:0] idx,
      input int n);
    logic live;
    live = dev == myAddr;
    if (setIdx) begin
      xfer(4'h8, {dev, RW_WRITE});
      xfer(4'h0, idx);
      check("index ack", 8'(live && present(idx)), 8'(rspAckd));
      expIndex = (live && present(idx)) ? idx : expIndex;
    end
    xfer(4'h8, {dev, RW_READ});
    check("read address ack", 8'(live), 8'(rspAckd));
    for (int i = 0; i < n; i++) begin
      xfer({1'h0, 1'(i == n - 1), 1'h1, 1'(i != n - 1)}, 8'h00);
      live = live && present(expIndex);
      check("read data", live ? expMem[expIndex] : READ_FILL, rspData);
      expIndex = live ? expIndex + INDEX_STEP : expIndex;
    end
    $display("read test done, %0d bytes", n);
  endtask
  initial begin
    int r;
    resetn = 1'h0;
    strapPin = 1'h0;
    cmdValid = 1'h0;
    cmdWord = 12'h000;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i * 7 + 3);
      expMem[i] = mem[i];
    end
    // second pass resets in mid-run with the other strap level
    for (int pass = 0; pass < 2; pass++) begin
      @(posedge clock);
      resetn <= 1'h0;
      strapPin <= 1'(pass);
      repeat (5) @(posedge clock);
      resetn <= 1'h1;
      repeat (6) @(posedge clock);
      myAddr = {DEV_ADDR_HI, strapPin};
      expIndex = INDEX_RESET;
      check("strap bit", 8'(pass), 8'(strapBit));
      strapPin <= ~strapPin;
      rd(myAddr, 1'h0, 8'h00, 1);
      wr(myAddr, 8'hff, 2);
      rd(myAddr, 1'h0, 8'h00, 1);
      wr(myAddr, 8'he3, 1);
      wr(myAddr, 8'hdf, 2);
      rd(myAddr, 1'h0, 8'h00, 1);
      rd(myAddr, 1'h1, 8'hfe, 3);
      wr(myAddr ^ 7'h01, 8'h10, 1);
      wr(myAddr ^ 7'h20, 8'h11, 1);
      rd(myAddr ^ 7'h01, 1'h0, 8'h00, 1);
      rd(myAddr, 1'h0, 8'h00, 2);
      for (int k = 0; k < 8; k++) begin
        r = $random(seed);
        if (r[0]) begin
          wr(myAddr, r[15:8], 1 + int'(r[2:1]) % 3);
        end else begin
          rd(myAddr, r[1], r[15:8], 1 + int'(r[3:2]) % 3);
        end
      end
      for (int i = 0; i < 256; i++) begin
        check("register content", expMem[i], mem[i]);
      end
      check("strap bit held", 8'(pass), 8'(strapBit));
      $display("pass %0d done", pass);
    end
    finishTest();
  end
endmodule // tb
